// [hdl/bus_ctl_pkg.sv]
package bus_ctl_pkg;

  // ****************************************************
  // Cycle status codes, high line first
  // ****************************************************
  localparam logic [2:0] ST_INTA = 3'h0;
  localparam logic [2:0] ST_IORD = 3'h1;
  localparam logic [2:0] ST_IOWR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_FETCH = 3'h4;
  localparam logic [2:0] ST_MRD = 3'h5;
  localparam logic [2:0] ST_MWR = 3'h6;
  localparam logic [2:0] ST_IDLE = 3'h7;

  // ****************************************************
  // Request kinds from the core
  // ****************************************************
  typedef enum logic [2:0] {
    REQ_INTA = 3'b000,
    REQ_IORD = 3'b001,
    REQ_IOWR = 3'b010,
    REQ_FETCH = 3'b100,
    REQ_MRD = 3'b101,
    REQ_MWR = 3'b110,
    REQ_RFSH = 3'b111
  } req_kind_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_END = 2'b11
  } phase_t;

  // Reset values of the outputs and synchroniser depth
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_RESOUT = 1'b1;
  localparam int SYNC_STAGES = 3;

endpackage

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RST_VAL = 1'b0 // Idle level of the pin
) (
  input wire logic clk_in, // Core clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic pin_in, // Asynchronous pin
  output logic level_out // Filtered level
);
  logic [2:0] sh_q;
  // Reset to the idle level, no false edge after reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_q <= {3{RST_VAL}};
    end else begin
      sh_q <= {sh_q[1:0], pin_in};
    end
  end
  // Change counts once second and third stage agree
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_out <= RST_VAL;
    end else if (sh_q[1] == sh_q[2]) begin
      level_out <= sh_q[2];
    end
  end
endmodule
`default_nettype wire

// [hdl/bus_ctl.sv]
// Behaviour
// - A cycle ends only with ready high, unless on-chip select drives it.
// - Reset low aborts any cycle and puts every pin at a defined level.
// - The reset output is high for as long as reset input is low.
// - The refresh strobe is low for a whole refresh cycle, else high.
// - Status shows 000 acknowledge, 001 I/O read, 010 I/O write.
// - Status shows 011 when halted and 100 for a queue fetch.
// - Status shows 101 memory read, 110 memory write, 111 when idle.
// - The write strobe is low only while write data drive the data bus; the data stay driven one clock longer.
// - The wait instruction stalls while test is high, resumes when low.
// - Upper select is low in memory cycles inside the upper range.
// - The read strobe is low during read cycles.
`timescale 1ns/1ps
`default_nettype none
module bus_ctl #(
  parameter int ADDR_W = 20
) (
  input wire logic core_clk_in, // Core clock 250 MHz
  input wire logic arst_n_in, // Reset input, active low
  input wire logic req_valid_in, // Core requests a cycle
  input wire bus_ctl_pkg::req_kind_t req_kind_in, // Cycle kind
  input wire logic [ADDR_W-1:0] req_addr_in, // Cycle address
  input wire logic req_cs_in, // Cycle decoded by on-chip select
  input wire logic halt_in, // Core halted
  input wire logic wait_insn_in, // Core executing wait instruction
  input wire logic [ADDR_W-1:0] upper_base_in, // Upper range start
  input wire logic ready_in, // Ready pin
  input wire logic test_n_in, // Test pin, active low
  output logic req_done_out, // One-cycle pulse, cycle finished
  output logic wait_stall_out, // Core must stall
  output logic [2:0] cycle_status_out, // Bit 2 is cycle_status_bit2_n
  output logic rd_strobe_n_out, // Read strobe
  output logic wr_strobe_n_out, // Write strobe
  output logic data_oe_out, // Drive write data on bus
  output logic rfsh_n_out, // Refresh strobe
  output logic ucs_n_out, // Upper-region select
  output logic resout_out // Reset output, active high
);
  import bus_ctl_pkg::*;

  if (ADDR_W < 2 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W out of range");
  end

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic ready_s;
  logic test_n_s;
  pin_sync #(
    .RST_VAL(1'b0)
  ) u_rdy (
    .clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(ready_in),
    .level_out(ready_s)
  );
  // Test pin idles high, no false resume after reset
  pin_sync #(
    .RST_VAL(1'b1)
  ) u_tst (
    .clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(test_n_in),
    .level_out(test_n_s)
  );

  function automatic logic is_mem(input req_kind_t k);
    return k == REQ_FETCH || k == REQ_MRD || k == REQ_MWR;
  endfunction

  function automatic logic [2:0] code_of(input req_kind_t k);
    case (k)
      REQ_INTA: return ST_INTA;
      REQ_IORD: return ST_IORD;
      REQ_IOWR: return ST_IOWR;
      REQ_FETCH: return ST_FETCH;
      REQ_MRD: return ST_MRD;
      REQ_MWR: return ST_MWR;
      default: return ST_IDLE;
    endcase
  endfunction

  // ****************************************************
  // Cycle sequencer
  // ****************************************************
  phase_t ph_q;
  req_kind_t kind_q;
  logic cs_q;
  logic [ADDR_W-1:0] addr_q;
  logic end_ok;

  assign end_ok = cs_q || ready_s;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ph_q <= PH_IDLE;
      kind_q <= REQ_RFSH;
      cs_q <= 1'b0;
      addr_q <= '0;
    end else begin
      case (ph_q)
        PH_IDLE: begin
          if (req_valid_in) begin
            ph_q <= PH_ADDR;
            kind_q <= req_kind_in;
            cs_q <= req_cs_in;
            addr_q <= req_addr_in;
          end
        end
        PH_ADDR: ph_q <= PH_DATA;
        PH_DATA: begin
          if (end_ok) begin
            ph_q <= PH_END;
          end
        end
        PH_END: ph_q <= PH_IDLE;
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

  logic active;
  logic in_upper;
  assign active = ph_q != PH_IDLE;
  assign in_upper = addr_q >= upper_base_in;

  // ****************************************************
  // Pin outputs
  // ****************************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cycle_status_out <= ST_IDLE;
      rd_strobe_n_out <= RST_STROBE_N;
      wr_strobe_n_out <= RST_STROBE_N;
      data_oe_out <= 1'b0;
      rfsh_n_out <= RST_STROBE_N;
      ucs_n_out <= RST_STROBE_N;
      req_done_out <= 1'b0;
    end else begin
      // Halt code when idle and halted
      if (ph_q == PH_IDLE && req_valid_in) begin
        cycle_status_out <= code_of(req_kind_in);
      end else if (ph_q == PH_ADDR || (ph_q == PH_DATA && !end_ok)) begin
        cycle_status_out <= code_of(kind_q);
      end else if (halt_in) begin
        cycle_status_out <= ST_HALT;
      end else begin
        cycle_status_out <= ST_IDLE;
      end
      rd_strobe_n_out <= !((ph_q == PH_ADDR || (ph_q == PH_DATA && !end_ok))
        && (kind_q == REQ_MRD || kind_q == REQ_IORD
        || kind_q == REQ_FETCH || kind_q == REQ_INTA));
      wr_strobe_n_out <= !((ph_q == PH_ADDR || (ph_q == PH_DATA && !end_ok))
        && (kind_q == REQ_MWR || kind_q == REQ_IOWR));
      data_oe_out <= active && (kind_q == REQ_MWR || kind_q == REQ_IOWR)
        && !(ph_q == PH_END);
      rfsh_n_out <= !((ph_q == PH_IDLE && req_valid_in
        && req_kind_in == REQ_RFSH)
        || (ph_q == PH_ADDR || ph_q == PH_DATA) && kind_q == REQ_RFSH);
      ucs_n_out <= !((ph_q == PH_ADDR || ph_q == PH_DATA)
        && is_mem(kind_q) && in_upper);
      req_done_out <= ph_q == PH_DATA && end_ok;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      resout_out <= RST_RESOUT;
    end else begin
      resout_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_stall_out <= 1'b0;
    end else begin
      wait_stall_out <= wait_insn_in && test_n_s;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  a_ready_hold: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (ph_q == PH_DATA && !cs_q && !ready_s) |=> ph_q == PH_DATA)
    else $error("cycle ended without ready");
  a_cs_ends: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (ph_q == PH_DATA && cs_q) |=> ph_q == PH_END)
    else $error("select cycle did not end");
  a_resout_low: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in) $rose(arst_n_in) |-> 1'b1 ##1 !resout_out)
    else $error("reset output stuck");
  a_idle_code: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (ph_q == PH_IDLE && !req_valid_in && !halt_in) |=>
    cycle_status_out == ST_IDLE)
    else $error("idle code wrong");
  a_halt_code: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (ph_q == PH_IDLE && !req_valid_in && halt_in) |=>
    cycle_status_out == ST_HALT)
    else $error("halt code wrong");
  a_start_code: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (ph_q == PH_IDLE && req_valid_in && req_kind_in == REQ_IORD) |=>
    cycle_status_out == ST_IORD ##1 cycle_status_out == ST_IORD)
    else $error("I/O read code wrong");
  a_rfsh_low: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (ph_q == PH_ADDR && kind_q == REQ_RFSH) |=> !rfsh_n_out)
    else $error("refresh strobe high");
  a_wr_excl: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    !wr_strobe_n_out |-> data_oe_out && rd_strobe_n_out)
    else $error("write strobe without data");
  a_wait_stall: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (wait_insn_in && test_n_s) |=> wait_stall_out)
    else $error("wait did not stall");
  a_ucs_io: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (ph_q == PH_ADDR && !is_mem(kind_q)) |=> ucs_n_out)
    else $error("select in non-memory cycle");
  c_mem_read: cover property (@(posedge core_clk_in)
    disable iff (!arst_n_in) ph_q == PH_DATA && kind_q == REQ_MRD && !end_ok);
  c_refresh: cover property (@(posedge core_clk_in)
    disable iff (!arst_n_in) !rfsh_n_out);
  c_stall: cover property (@(posedge core_clk_in)
    disable iff (!arst_n_in) wait_stall_out);
endmodule
`default_nettype wire

// [dv/bus_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module bus_far_side (
  input wire logic clk_in, // Core clock
  input wire logic rd_strobe_n_in, // Read strobe
  input wire logic wr_strobe_n_in, // Write strobe
  input wire logic rfsh_n_in, // Refresh strobe
  input wire logic [7:0] delay_in, // Wait states before ready
  output logic ready_out // Ready pin
);
  // ****************************************************
  // Memory or I/O device answering a strobe
  // ****************************************************
  logic [7:0] cnt_q = 8'h00;
  logic ready_q = 1'b0;
  logic sel;
  assign sel = !rd_strobe_n_in || !wr_strobe_n_in || !rfsh_n_in;
  assign ready_out = ready_q;
  always @(posedge clk_in) begin
    cnt_q <= sel ? cnt_q + 8'h01 : 8'h00;
    ready_q <= sel && (cnt_q >= delay_in);
  end
endmodule
`default_nettype wire

// [dv/bus_ctl_test.sv]
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_test;
  import bus_ctl_pkg::*;
  typedef struct {
    req_kind_t k;
    logic [19:0] a;
    logic [2:0] st;
    logic rd, wr, ucs, rf;
  } row_t;
  // ****************************************************
  // Stimulus and checks
  // ****************************************************
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, cs = 1'b0, halt = 1'b0;
  logic wins = 1'b0, test_n = 1'b1, ready;
  req_kind_t kind = REQ_MRD;
  logic [19:0] addr = 20'h0_0000, base = 20'h8_0000;
  logic [7:0] dly = 8'h00;
  logic done, stall, rd_n, wr_n, oe, rf_n, ucs_n, resout;
  logic [2:0] stat;
  int n_errors = 0, checks = 0, n = 0, cyc = 0;
  row_t rows [8] = '{
    '{REQ_INTA, 20'h0_0000, ST_INTA, 1'b0, 1'b1, 1'b1, 1'b1},
    '{REQ_IORD, 20'h9_0000, ST_IORD, 1'b0, 1'b1, 1'b1, 1'b1},
    '{REQ_IOWR, 20'h9_0000, ST_IOWR, 1'b1, 1'b0, 1'b1, 1'b1},
    '{REQ_FETCH, 20'h9_0000, ST_FETCH, 1'b0, 1'b1, 1'b0, 1'b1},
    '{REQ_MRD, 20'h7_FFFF, ST_MRD, 1'b0, 1'b1, 1'b1, 1'b1},
    '{REQ_MRD, 20'h8_0000, ST_MRD, 1'b0, 1'b1, 1'b0, 1'b1},
    '{REQ_MWR, 20'hF_FFFF, ST_MWR, 1'b1, 1'b0, 1'b0, 1'b1},
    '{REQ_RFSH, 20'h0_0000, ST_IDLE, 1'b1, 1'b1, 1'b1, 1'b0}};
  always #2 clk = ~clk;
  bus_ctl dut (.core_clk_in(clk), .arst_n_in(rst_n), .req_valid_in(valid),
    .req_kind_in(kind), .req_addr_in(addr), .req_cs_in(cs),
    .halt_in(halt), .wait_insn_in(wins), .upper_base_in(base),
    .ready_in(ready), .test_n_in(test_n), .req_done_out(done),
    .wait_stall_out(stall), .cycle_status_out(stat),
    .rd_strobe_n_out(rd_n), .wr_strobe_n_out(wr_n), .data_oe_out(oe),
    .rfsh_n_out(rf_n), .ucs_n_out(ucs_n), .resout_out(resout));
  bus_far_side far (.clk_in(clk), .rd_strobe_n_in(rd_n),
    .wr_strobe_n_in(wr_n), .rfsh_n_in(rf_n), .delay_in(dly),
    .ready_out(ready));
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic run(input row_t r, input logic c);
    @(negedge clk);
    valid = 1'b1;
    kind = r.k;
    addr = r.a;
    cs = c;
    @(negedge clk);
    valid = 1'b0;
    chk(stat, r.st);
    // Read and write strobes follow one clock after the status code, refresh strobe comes with it
    @(negedge clk);
    chk(stat, r.st);
    chk(rd_n, r.rd);
    chk({wr_n, oe}, {r.wr, ~r.wr});
    chk(ucs_n, r.ucs);
    chk(rf_n, r.rf);
    n = 1;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(done, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    chk({resout, stat, rd_n, wr_n, rf_n, done}, 8'hFE);
    chk({ucs_n, oe, stall}, 3'h4);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(resout, 1'b0);
    foreach (rows[i]) begin
      run(rows[i], 1'b0);
      chk(stat, ST_IDLE);
      run(rows[i], 1'b1);
    end
    // Let the filtered ready of the last refresh fall
    repeat (8) @(negedge clk);
    dly = 8'h1E;
    run(rows[4], 1'b0);
    chk(n > 30, 1'b1);
    run(rows[4], 1'b1);
    chk(n < 8, 1'b1);
    dly = 8'h00;
    halt = 1'b1;
    run(rows[1], 1'b0);
    @(negedge clk);
    chk(stat, ST_HALT);
    halt = 1'b0;
    wins = 1'b1;
    repeat (8) @(negedge clk);
    chk(stall, 1'b1);
    test_n = 1'b0;
    repeat (8) @(negedge clk);
    chk(stall, 1'b0);
    wins = 1'b0;
    dly = 8'h63;
    valid = 1'b1;
    kind = REQ_MWR;
    @(negedge clk);
    valid = 1'b0;
    @(negedge clk);
    rst_n = 1'b0;
    #1;
    chk({resout, stat, wr_n, oe, ucs_n, done}, 8'hFA);
    @(negedge clk);
    chk(resout, 1'b1);
    rst_n = 1'b1;
    dly = 8'h00;
    // Stall must hold from the first clock after reset
    test_n = 1'b1;
    wins = 1'b1;
    @(negedge clk);
    chk(stall, 1'b1);
    wins = 1'b0;
    repeat (3) @(negedge clk);
    run(rows[6], 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
